// *** fsp_map.vh ***
// Register map, field layout and timing constants of the flash self-programming sequencer
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define FSP_OFS_CONTROL   8'h00
`define FSP_OFS_POINTER   8'h04
`define FSP_OFS_DATA_LOW  8'h08
`define FSP_OFS_DATA_HIGH 8'h0C
`define FSP_OFS_STATUS    8'h10

// ****************************************
// Control register fields
// ****************************************
`define FSP_CMD_W         6
`define FSP_CMD_LOAD      6'h01
`define FSP_CMD_ERASE     6'h03
`define FSP_CMD_WRITE     6'h05
`define FSP_CMD_CLEAR     6'h11
`define FSP_CMD_NONE      6'h00
`define FSP_BIT_ARM       0
`define FSP_BIT_ERASE     1
`define FSP_BIT_WRITE     2
`define FSP_BIT_CLEAR     4

// ****************************************
// Pointer layout: bit 0 ignored, word in page, page index
// ****************************************
`define FSP_PTR_W         16
`define FSP_WORD_LSB      1
`define FSP_WORD_MSB      5
`define FSP_WORD_W        5
`define FSP_PAGE_LSB      6
`define FSP_PAGE_MSB      15
`define FSP_PAGE_W        10
`define FSP_PAGE_WORDS    32
`define FSP_ERASED_WORD   16'hFFFF

// ****************************************
// Timing
// ****************************************
`define FSP_ARM_CYCLES    3'h4
// Default operation times: 4 ms each at 250 MHz, already sized to the timer
`define FSP_ERASE_CYCLES  24'h0F_4240
`define FSP_WRITE_CYCLES  24'h0F_4240
`define FSP_TMR_W         24

`endif

// *** fsp_sequencer.v ***
// Flash page self-programming sequencer with an AHB-Lite register slave
`timescale 1ns/100ps
`include "fsp_map.vh"
// Function
// - Program flash only as whole pages from buffer
// - Buffer filled one word per store instruction
// - Buffer words loadable in any order
// - Erase command plus store within four cycles
// - Erase uses page index only
// - Core stalled during whole erase
// - Load command stores both data registers
// - Word field picks buffer location
// - Buffer cleared after write, clear bit, reset
// - EEPROM write discards loaded buffer data
// - Write command programs buffer to page
// - Core stalled during whole page write
// - Arm bit lasts four cycles, to a load store, or to operation end
// - Undefined command patterns have no effect
// - Clear bit discards buffer contents
// - EEPROM write blocks writes of all programming commands

module fsp_sequencer
#(
	parameter [`FSP_TMR_W-1:0] ERASE_CYCLES = `FSP_ERASE_CYCLES,
	parameter [`FSP_TMR_W-1:0] WRITE_CYCLES = `FSP_WRITE_CYCLES
)
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Core side
	input  wire        storeProgReq,
	output reg         coreStall,
	// EEPROM side
	input  wire        eepromBusy,
	input  wire        eepromWriteStart,
	// Flash array side
	output reg         flashEraseReq,
	output reg  [9:0]  flashPageAddr,
	output reg         flashWordWe,
	output reg  [4:0]  flashWordAddr,
	output reg  [15:0] flashWordData,
	output reg         flashBusy
);

	// ****************************************
	// Local state
	// ****************************************
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_ERASE = 2'h1;
	localparam [1:0] ST_WRITE = 2'h2;

	reg  [1:0]              stateReg;
	reg  [`FSP_CMD_W-1:0]   cmdReg;
	reg  [2:0]              armCntReg;
	reg  [`FSP_PTR_W-1:0]   pointerReg;
	reg  [7:0]              dataLowReg;
	reg  [7:0]              dataHighReg;
	reg  [`FSP_TMR_W-1:0]   timerReg;
	reg  [`FSP_WORD_W:0]    streamIdxReg;
	reg  [15:0]             bufMem [0:`FSP_PAGE_WORDS-1];
	reg  [`FSP_PAGE_WORDS-1:0] bufValidReg;
	reg                     wrPendReg;
	reg  [7:0]              wrAddrReg;
	reg                     opDoneReg;

	wire                    addrPhase;
	wire                    ctrlWrite;
	wire [`FSP_CMD_W-1:0]   wrCmd;
	wire                    armed;
	wire                    fire;
	wire                    bufClear;
	wire [`FSP_WORD_W-1:0]  loadIdx;
	wire [`FSP_WORD_W-1:0]  streamIdx;

	// Buffer word as seen by the flash; unloaded words program as erased
	function [15:0] buf_word;
		input [`FSP_WORD_W-1:0] idx;
		input                   valid;
		input [15:0]            word;
		begin
			buf_word = valid ? word : `FSP_ERASED_WORD;
		end
	endfunction

	// Only the documented command patterns are accepted
	function cmd_legal;
		input [`FSP_CMD_W-1:0] cmd;
		begin
			cmd_legal = (cmd == `FSP_CMD_LOAD) || (cmd == `FSP_CMD_ERASE) ||
				(cmd == `FSP_CMD_WRITE) || (cmd == `FSP_CMD_CLEAR);
		end
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	// Zero wait states, so the data phase always follows the address phase by one cycle
	assign addrPhase = hsel & htrans[1] & hready;
	assign wrCmd     = hwdata[`FSP_CMD_W-1:0];
	// Command writes are dropped while an EEPROM write runs or an operation is busy
	assign ctrlWrite = wrPendReg & (wrAddrReg == `FSP_OFS_CONTROL) & ~eepromBusy & (stateReg == ST_IDLE);
	assign armed     = (armCntReg != 3'h0);
	assign fire      = armed & storeProgReq & ~ctrlWrite & (stateReg == ST_IDLE);
	assign loadIdx   = pointerReg[`FSP_WORD_MSB:`FSP_WORD_LSB];
	assign streamIdx = streamIdxReg[`FSP_WORD_W-1:0];
	// Clear sources: clear command, EEPROM write mid-fill, end of page write
	assign bufClear  = (ctrlWrite & cmd_legal(wrCmd) & wrCmd[`FSP_BIT_CLEAR]) |
		eepromWriteStart |
		(opDoneReg & (stateReg == ST_WRITE));

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	// Read data is prepared in the address phase so it stands in the data phase
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			wrPendReg <= 1'b0;
			wrAddrReg <= 8'h00;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wrPendReg <= addrPhase & hwrite;
			wrAddrReg <= haddr;
			if (addrPhase & ~hwrite)
			begin
				case (haddr)
					`FSP_OFS_CONTROL:   hrdata <= {26'h0, cmdReg & {`FSP_CMD_W{armed | (stateReg != ST_IDLE)}}};
					`FSP_OFS_POINTER:   hrdata <= {16'h0000, pointerReg};
					`FSP_OFS_DATA_LOW:  hrdata <= {24'h00_0000, dataLowReg};
					`FSP_OFS_DATA_HIGH: hrdata <= {24'h00_0000, dataHighReg};
					`FSP_OFS_STATUS:    hrdata <= {29'h0, eepromBusy, armed, stateReg != ST_IDLE};
					default:            hrdata <= 32'h0000_0000; // Unmapped reads zero
				endcase
			end
		end
	end

	// ****************************************
	// Pointer and data registers
	// ****************************************
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pointerReg  <= 16'h0000;
			dataLowReg  <= 8'h00;
			dataHighReg <= 8'h00;
		end
		else if (wrPendReg)
		begin
			if (wrAddrReg == `FSP_OFS_POINTER)
				pointerReg <= hwdata[`FSP_PTR_W-1:0];
			if (wrAddrReg == `FSP_OFS_DATA_LOW)
				dataLowReg <= hwdata[7:0];
			if (wrAddrReg == `FSP_OFS_DATA_HIGH)
				dataHighReg <= hwdata[7:0];
		end
	end

	// ****************************************
	// Command arming window
	// ****************************************
	// The arm bit holds for four cycles, until a load store, or until an erase or write ends
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cmdReg    <= `FSP_CMD_NONE;
			armCntReg <= 3'h0;
		end
		else if (ctrlWrite & cmd_legal(wrCmd) & ~wrCmd[`FSP_BIT_CLEAR])
		begin
			cmdReg    <= wrCmd;
			armCntReg <= `FSP_ARM_CYCLES;
		end
		else if (ctrlWrite & cmd_legal(wrCmd))
			cmdReg <= `FSP_CMD_NONE; // Clear acts at once and arms nothing
		else if (fire)
			armCntReg <= 3'h0;
		else if (opDoneReg)
			cmdReg <= `FSP_CMD_NONE;
		else if (armed)
		begin
			armCntReg <= armCntReg - 3'h1;
			if (armCntReg == 3'h1)
				cmdReg <= `FSP_CMD_NONE; // Timeout
		end
		// Any other pattern leaves the sequencer untouched
	end

	// ****************************************
	// Temporary page buffer
	// ****************************************
	// Valid bits stand in for resetting the array to erased 16'hFFFF words; a load in the clear cycle still lands
	always @(posedge mclk)
	begin
		if (!rst_n)
			bufValidReg <= {`FSP_PAGE_WORDS{1'b0}};
		else
		begin
			if (bufClear)
				bufValidReg <= {`FSP_PAGE_WORDS{1'b0}};
			if (fire && (cmdReg == `FSP_CMD_LOAD))
				bufValidReg[loadIdx] <= 1'b1;
		end
	end

	// Word store; any location in any order, one word per store
	always @(posedge mclk)
	begin
		if (fire && (cmdReg == `FSP_CMD_LOAD))
			bufMem[loadIdx] <= {dataHighReg, dataLowReg};
	end

	// ****************************************
	// Erase and write sequencer
	// ****************************************
	// Stall rises the edge after the store and falls when the timer expires
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stateReg      <= ST_IDLE;
			timerReg      <= {`FSP_TMR_W{1'b0}};
			streamIdxReg  <= {(`FSP_WORD_W+1){1'b0}};
			coreStall     <= 1'b0;
			flashBusy     <= 1'b0;
			flashEraseReq <= 1'b0;
			flashPageAddr <= 10'h000;
			flashWordWe   <= 1'b0;
			flashWordAddr <= 5'h00;
			flashWordData <= 16'h0000;
			opDoneReg     <= 1'b0;
		end
		else
		begin
			flashEraseReq <= 1'b0;
			flashWordWe   <= 1'b0;
			opDoneReg     <= 1'b0;
			case (stateReg)
				ST_IDLE:
				begin
					if (fire && (cmdReg == `FSP_CMD_ERASE))
					begin
						stateReg      <= ST_ERASE;
						flashPageAddr <= pointerReg[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
						flashEraseReq <= 1'b1;
						timerReg      <= ERASE_CYCLES;
						coreStall     <= 1'b1;
						flashBusy     <= 1'b1;
					end
					else if (fire && (cmdReg == `FSP_CMD_WRITE))
					begin
						stateReg      <= ST_WRITE;
						flashPageAddr <= pointerReg[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
						streamIdxReg  <= {(`FSP_WORD_W+1){1'b0}};
						timerReg      <= WRITE_CYCLES;
						coreStall     <= 1'b1;
						flashBusy     <= 1'b1;
					end
				end
				ST_ERASE, ST_WRITE:
				begin
					// The whole page goes out from the buffer, never single words
					if ((stateReg == ST_WRITE) && !streamIdxReg[`FSP_WORD_W])
					begin
						flashWordWe   <= 1'b1;
						flashWordAddr <= streamIdx;
						flashWordData <= buf_word(streamIdx, bufValidReg[streamIdx], bufMem[streamIdx]);
						streamIdxReg  <= streamIdxReg + 6'h01;
					end
					if (timerReg <= 24'h00_0001)
					begin
						opDoneReg <= 1'b1;
						coreStall <= 1'b0;
						flashBusy <= 1'b0;
					end
					else
						timerReg <= timerReg - 24'h00_0001;
					if (opDoneReg)
						stateReg <= ST_IDLE;
				end
				default:
					stateReg <= ST_IDLE;
			endcase
		end
	end

endmodule // fsp_sequencer

// *** fsp_seq_monitor.sv ***
// Checker watching the sequencer's core and flash ports
`timescale 1ns/100ps
module fsp_monitor
#(
	parameter [23:0] ERASE_CYCLES = 24'h000028,
	parameter [23:0] WRITE_CYCLES = 24'h000032
)
(
	// Clock and reset
	input wire       mclk,
	input wire       rst_n,
	// Core side
	input wire       storeProgReq,
	input wire       coreStall,
	// Flash side
	input wire       flashBusy,
	input wire       flashEraseReq,
	input wire       flashWordWe,
	input wire [4:0] flashWordAddr
);
	reg [23:0] stallCnt_reg;
	reg [5:0]  weCnt_reg;
	reg        wasErase_reg;
	// ****
	// Per-operation counters, cleared between operations
	// ****
	always @(posedge mclk)
	begin
		if (!rst_n || !coreStall)
		begin
			stallCnt_reg <= 24'h000000;
			weCnt_reg <= 6'h00;
			wasErase_reg <= 1'b0;
		end
		else
		begin
			stallCnt_reg <= stallCnt_reg + 24'h000001;
			weCnt_reg <= weCnt_reg + {5'h00, flashWordWe};
			wasErase_reg <= wasErase_reg | flashEraseReq;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence stallRise;
		$rose(coreStall);
	endsequence
	sequence eraseStep;
		flashEraseReq ##1 !flashEraseReq;
	endsequence
	stall_busy_a: assert property (coreStall == flashBusy)
		else $error("stall and busy differ");
	stall_cause_a: assert property (stallRise |-> $past(storeProgReq))
		else $error("stall without store");
	erase_start_a: assert property (flashEraseReq |-> stallRise)
		else $error("erase start without stall");
	erase_pulse_a: assert property (flashEraseReq |-> eraseStep)
		else $error("erase request too long");
	stall_len_a: assert property ($fell(coreStall) |->
		stallCnt_reg == (wasErase_reg ? ERASE_CYCLES : WRITE_CYCLES))
		else $error("stall length wrong");
	we_in_stall_a: assert property (flashWordWe |-> coreStall)
		else $error("word streamed outside stall");
	whole_page_a: assert property ($fell(coreStall) && !wasErase_reg |-> weCnt_reg == 6'h20)
		else $error("page write not whole page");
	word_first_a: assert property ($rose(flashWordWe) |-> flashWordAddr == 5'h00)
		else $error("stream not from word zero");
	word_seq_a: assert property (flashWordWe && $past(flashWordWe) |->
		flashWordAddr == $past(flashWordAddr) + 5'h01)
		else $error("stream order wrong");
endmodule // fsp_monitor

// *** fsp_core_model.sv ***
// Behavioural core issuing store-program instructions
`timescale 1ns/100ps
module fsp_core_model
(
	// Clock
	input  wire mclk,
	// Bench request and sequencer stall
	input  wire fire,
	input  wire coreStall,
	// Store strobe
	output reg  storeProgReq
);
	initial storeProgReq = 1'b0;
	// A halted core executes nothing, so stores requested during the stall are dropped
	always @(posedge mclk)
	begin
		storeProgReq <= fire && !coreStall;
	end
endmodule // fsp_core_model

// *** flash_page_self_programming_bench.sv ***
// Self-checking bench of the flash self-programming sequencer
`timescale 1ns/100ps
`include "fsp_map.vh"
module flash_page_self_programming_bench;
	localparam [23:0] EC = 24'h000028;
	localparam [23:0] WC = 24'h000032;
	reg         mclk, rst_n, hsel, hwrite, fire, eepromBusy, eepromWriteStart;
	reg  [7:0]  haddr;
	reg  [1:0]  htrans;
	reg  [31:0] hwdata, rd;
	wire        hreadyout, hresp, coreStall, storeProgReq, flashEraseReq, flashWordWe, flashBusy;
	wire [31:0] hrdata;
	wire [9:0]  flashPageAddr;
	wire [4:0]  flashWordAddr;
	wire [15:0] flashWordData;
	reg  [15:0] expBuf [0:31];
	integer     miscompares, n_tests, i;
	// ****
	// Design, core model, clock
	// ****
	fsp_sequencer #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC)) dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .storeProgReq(storeProgReq),
		.coreStall(coreStall), .eepromBusy(eepromBusy), .eepromWriteStart(eepromWriteStart),
		.flashEraseReq(flashEraseReq), .flashPageAddr(flashPageAddr), .flashWordWe(flashWordWe),
		.flashWordAddr(flashWordAddr), .flashWordData(flashWordData), .flashBusy(flashBusy));
	fsp_core_model core_u (.mclk(mclk), .fire(fire), .coreStall(coreStall), .storeProgReq(storeProgReq));
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// ****
	// Tasks
	// ****
	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		n_tests = n_tests + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("mismatch %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	// One AHB single transfer; read data taken at the data-phase edge
	task bus(input w, input [7:0] a, input [31:0] d);
	begin
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
		chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
	end
	endtask
	task clearExp;
		for (i = 0; i < 32; i = i + 1) expBuf[i] = `FSP_ERASED_WORD;
	endtask
	// Store issued d cycles after the command edge; arm covers d up to 2
	task store(input integer d);
	begin
		repeat (d) @(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		@(posedge mclk);
	end
	endtask
	task load(input [15:0] p, input [15:0] dt, input [5:0] cmd, input integer d, input ok);
	begin
		bus(1'b1, `FSP_OFS_POINTER, {16'h0000, p});
		bus(1'b1, `FSP_OFS_DATA_LOW, {24'h000000, dt[7:0]});
		bus(1'b1, `FSP_OFS_DATA_HIGH, {24'h000000, dt[15:8]});
		bus(1'b1, `FSP_OFS_CONTROL, {26'h0000000, cmd});
		store(d);
		if (ok) expBuf[p[5:1]] = dt;
	end
	endtask
	// Erase or write; watches stall length, streamed words and page address
	task pageOp(input [15:0] p, input [5:0] cmd, input [23:0] len);
		integer n, words;
	begin
		bus(1'b1, `FSP_OFS_POINTER, {16'h0000, p});
		bus(1'b1, `FSP_OFS_CONTROL, {26'h0000000, cmd});
		store(0);
		@(posedge mclk); // Stall launched at the store edge is visible from the next edge
		n = 0;
		words = 0;
		while (coreStall === 1'b1 && n < 300)
		begin
			if (flashWordWe === 1'b1) chk("word", {16'h0000, expBuf[flashWordAddr]}, {16'h0000, flashWordData});
			if (flashWordWe === 1'b1) words = words + 1;
			if (flashEraseReq === 1'b1) words = words + 100;
			@(posedge mclk);
			n = n + 1;
		end
		chk("stall", {8'h00, len}, n);
		chk("page", {22'h000000, p[15:6]}, {22'h000000, flashPageAddr});
		chk("words", (cmd == `FSP_CMD_WRITE) ? 32 : 100, words);
		if (cmd == `FSP_CMD_WRITE) clearExp;
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	// ****
	// Scenarios
	// ****
	// Register read-back and the arm window as software sees it
	task testRegs;
	begin
		bus(1'b1, `FSP_OFS_POINTER, 32'h0000_A5C2);
		bus(1'b0, `FSP_OFS_POINTER, 32'h0000_0000);
		chk("pointer", 32'h0000_A5C2, rd);
		bus(1'b1, `FSP_OFS_CONTROL, {26'h0000000, `FSP_CMD_LOAD});
		bus(1'b0, `FSP_OFS_CONTROL, 32'h0000_0000);
		chk("control armed", {26'h0000000, `FSP_CMD_LOAD}, rd);
		bus(1'b0, `FSP_OFS_STATUS, 32'h0000_0000);
		chk("status armed", 32'h0000_0002, rd);
		bus(1'b0, `FSP_OFS_CONTROL, 32'h0000_0000);
		chk("control expired", 32'h0000_0000, rd);
		$display("test regs done");
	end
	endtask
	task testFill;
	begin
		bus(1'b1, `FSP_OFS_CONTROL, {26'h0000000, `FSP_CMD_CLEAR});
		clearExp;
		load(16'hA94A, 16'h1234, `FSP_CMD_LOAD, 2, 1'b1);
		load(16'hA944, 16'hBEEF, `FSP_CMD_LOAD, 0, 1'b1);
		load(16'hA94E, 16'h5555, `FSP_CMD_LOAD, 3, 1'b0);
		pageOp(16'hA97F, `FSP_CMD_ERASE, EC);
		pageOp(16'hA940, `FSP_CMD_WRITE, WC);
		pageOp(16'hA940, `FSP_CMD_WRITE, WC);
		$display("test fill done");
	end
	endtask
	task testDiscard;
	begin
		load(16'h0006, 16'h0303, `FSP_CMD_LOAD, 0, 1'b1);
		bus(1'b1, `FSP_OFS_CONTROL, {26'h0000000, `FSP_CMD_CLEAR});
		clearExp;
		load(16'h0008, 16'h0404, `FSP_CMD_LOAD, 0, 1'b1);
		eepromWriteStart <= 1'b1;
		@(posedge mclk);
		eepromWriteStart <= 1'b0;
		clearExp;
		load(16'h000C, 16'h0606, 6'h07, 0, 1'b0);
		load(16'h000E, 16'h0707, 6'h09, 0, 1'b0);
		load(16'h0010, 16'h0808, 6'h21, 0, 1'b0);
		eepromBusy <= 1'b1;
		load(16'h0012, 16'h0909, `FSP_CMD_LOAD, 0, 1'b0);
		eepromBusy <= 1'b0;
		load(16'h0014, 16'hA5C3, `FSP_CMD_LOAD, 0, 1'b1);
		pageOp(16'h0040, `FSP_CMD_ERASE, EC);
		pageOp(16'h0040, `FSP_CMD_WRITE, WC);
		$display("test discard done");
	end
	endtask
	// ****
	// Main sequence and watchdog
	// ****
	initial
	begin
		miscompares = 0;
		n_tests = 0;
		{rst_n, hsel, hwrite, fire, eepromBusy, eepromWriteStart} = 6'h00;
		haddr = 8'h00;
		htrans = 2'b00;
		hwdata = 32'h00000000;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		bus(1'b0, `FSP_OFS_STATUS, 32'h00000000);
		chk("status", 32'h00000000, rd);
		bus(1'b0, 8'h20, 32'h00000000);
		chk("unmapped", 32'h00000000, rd);
		testRegs;
		testFill;
		testDiscard;
		end_sim;
	end
	initial
	begin
		#80000;
		miscompares = miscompares + 1;
		end_sim;
	end
endmodule // flash_page_self_programming_bench
bind fsp_sequencer fsp_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) mon_u (.mclk(mclk),
	.rst_n(rst_n), .storeProgReq(storeProgReq), .coreStall(coreStall), .flashBusy(flashBusy),
	.flashEraseReq(flashEraseReq), .flashWordWe(flashWordWe), .flashWordAddr(flashWordAddr));
